//--- core/tmrc_defines.vh
`ifndef TMRC_DEFINES_VH
`define TMRC_DEFINES_VH
// ==========================================================
// Register byte addresses
`define TMRC_ADDR_A_CTL 8'h00
`define TMRC_ADDR_A_CNT 8'h04
`define TMRC_ADDR_E_CTL 8'h08
`define TMRC_ADDR_E_CNT 8'h0C
`define TMRC_ADDR_O_CTL 8'h10
`define TMRC_ADDR_O_CNT 8'h14
// ==========================================================
// Control field positions
`define TMRC_BIT_ON 15
`define TMRC_BIT_IDLE_STOP 13
`define TMRC_BIT_ASYNC_WRITE_BLOCK 12
`define TMRC_BIT_WRITE_PENDING_FLAG 11
`define TMRC_BIT_GATE 7
`define TMRC_BIT_PAIR 3
`define TMRC_BIT_SYNC 2
`define TMRC_BIT_CS 1
`define TMRC_A_PS_HI 5
`define TMRC_A_PS_LO 4
`define TMRC_B_PS_HI 6
`define TMRC_B_PS_LO 4
// ==========================================================
// Writable masks and reset values
`define TMRC_A_WMASK 32'h0000B0B6
`define TMRC_E_WMASK 32'h0000A0FA
`define TMRC_O_WMASK 32'h0000A0F2
`define TMRC_CTL_RESET 32'h00000000
`define TMRC_CNT_RESET 16'h0000
// ==========================================================
// Timing and bus answers
`define TMRC_ASYNC_WR_CYCLES 3
`define TMRC_RESP_OKAY 2'h0
`define TMRC_RESP_SLVERR 2'h2
`endif

//--- core/tmrc_top.v
// Function
// RULE_01: A timer counts only while its enable bit is set and stops when it is cleared.
// RULE_02: With idle-stop set the timer halts while the device is idle, else it keeps running.
// RULE_03: On timer A with write-block set, a count write during a pending async write is dropped.
// RULE_04: Timer A write-pending flag reads 1 during an async count write and 0 in sync mode.
// RULE_05: Gate-accumulate enables gated counting only when clock-source select is 0.
// RULE_06: On type B timers gate-accumulate reads 0 and has no effect while clock source is 1.
// RULE_07: Timer A prescale codes 11,10,01,00 divide by 256, 64, 8 and 1.
// RULE_08: Type B prescale codes 111 down to 000 divide by 256,64,32,16,8,4,2,1.
// RULE_09: The 32-bit pairing bit exists only on the even type B timer.
// RULE_10: In 32-bit mode the odd timer's enable, gate, prescale and source bits are ignored.
// RULE_11: Software clears idle-stop on the odd timer to keep a 32-bit pair running in idle.
// RULE_12: Unimplemented control bits ignore writes and read 0; implemented bits reset to 0.
// RULE_13: Software avoids register access in the cycle right after clearing enable.
// RULE_14: An enabled, ungated timer counts once per prescaled input clock period.
// RULE_15: In gated mode the timer counts only while its gate input is high.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "tmrc_defines.vh"

module tmrc_top #(
  parameter ASYNC_WR_CYCLES = `TMRC_ASYNC_WR_CYCLES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire awvalid,
  output reg awready,
  input wire [7:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read
  input wire arvalid,
  output reg arready,
  input wire [7:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Device and timer pins: index 0 timer A, 1 even B, 2 odd B
  input wire idle_mode,
  input wire [2:0] gate_in,
  input wire [2:0] ext_clk_in
);

  // ==========================================================
  // Pin synchronisers
  reg [6:0] sync1;
  reg [6:0] sync2;
  reg [6:0] sync3;
  reg [6:0] pin_state;
  reg [2:0] ext_prev;

  // Three stages; a change counts once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sync3 <= 7'h00;
      pin_state <= 7'h00;
      ext_prev <= 3'h0;
    end else begin
      sync1 <= {idle_mode, gate_in, ext_clk_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_state <= (sync2 & sync3) | (pin_state & (sync2 | sync3));
      ext_prev <= pin_state[2:0];
    end
  end

  wire idle_s = pin_state[6];
  wire [2:0] gate_s = pin_state[5:3];
  wire [2:0] ext_rise = pin_state[2:0] & ~ext_prev;

  // ==========================================================
  // Control registers
  reg [31:0] a_ctl;
  reg [31:0] e_ctl;
  reg [31:0] o_ctl;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire wr_go = aw_held && w_held && !bvalid;
  wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Merge strobed bytes into a register under its writable mask
  function [31:0] merge;
    input [31:0] old;
    input [31:0] mask;
    input [31:0] data;
    input [31:0] bm;
    begin
      merge = ((old & ~bm) | (data & bm)) & mask;
    end
  endfunction

  // Unimplemented bits stay zero through the writable mask
  // RULE_12 mask and reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      a_ctl <= `TMRC_CTL_RESET;
      e_ctl <= `TMRC_CTL_RESET;
      o_ctl <= `TMRC_CTL_RESET;
    end else if (wr_go) begin
      if (aw_addr == `TMRC_ADDR_A_CTL) begin
        a_ctl <= merge(a_ctl, `TMRC_A_WMASK, w_data, byte_mask);
      end else if (aw_addr == `TMRC_ADDR_E_CTL) begin
        e_ctl <= merge(e_ctl, `TMRC_E_WMASK, w_data, byte_mask);
      end else if (aw_addr == `TMRC_ADDR_O_CTL) begin
        // RULE_09 no pair bit on odd
        o_ctl <= merge(o_ctl, `TMRC_O_WMASK, w_data, byte_mask);
      end
    end
  end

  // ==========================================================
  // Timer A asynchronous count write
  wire a_async = a_ctl[`TMRC_BIT_CS] && !a_ctl[`TMRC_BIT_SYNC];
  reg a_pending;
  reg [7:0] a_wait;
  reg [15:0] a_wr_val;
  wire a_cnt_wr = wr_go && (aw_addr == `TMRC_ADDR_A_CNT);
  // RULE_03 block while pending
  wire a_wr_take = a_cnt_wr && !(a_ctl[`TMRC_BIT_ASYNC_WRITE_BLOCK] && a_pending);
  wire a_done = a_pending && (a_wait == 8'h00);

  // An async write lands some cycles later, as if crossing into the external clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      a_pending <= 1'b0;
      a_wait <= 8'h00;
      a_wr_val <= `TMRC_CNT_RESET;
    end else if (a_wr_take && a_async) begin
      a_pending <= 1'b1;
      a_wait <= ASYNC_WR_CYCLES[7:0] - 8'h01;
      a_wr_val <= (a_wr_val & ~byte_mask[15:0]) | (w_data[15:0] & byte_mask[15:0]);
    end else if (a_done || !a_async) begin
      a_pending <= 1'b0;
    end else if (a_pending) begin
      a_wait <= a_wait - 8'h01;
    end
  end

  // RULE_04 flag only in async mode
  wire a_write_pending_flag = a_pending && a_async;

  // ==========================================================
  // Effective per-timer controls
  reg [2:0] t_en;
  reg [2:0] t_stop;
  reg [2:0] t_cs;
  reg [2:0] t_gate;
  reg [2:0] t_ld;
  reg [47:0] t_ld_val;
  reg [11:0] t_shift;
  wire pair = e_ctl[`TMRC_BIT_PAIR];

  // Shift amount for the prescale divider
  // RULE_07 timer A divisors
  function [3:0] a_shift;
    input [1:0] code;
    begin
      case (code)
        2'h3: a_shift = 4'h8;
        2'h2: a_shift = 4'h6;
        2'h1: a_shift = 4'h3;
        default: a_shift = 4'h0;
      endcase
    end
  endfunction

  // RULE_08 type B divisors
  function [3:0] b_shift;
    input [2:0] code;
    begin
      if (code == 3'h7) begin
        b_shift = 4'h8;
      end else begin
        b_shift = {1'b0, code};
      end
    end
  endfunction

  // Odd timer defers to even settings in a pair
  always @* begin
    // RULE_01 enable bits
    t_en = {o_ctl[`TMRC_BIT_ON], e_ctl[`TMRC_BIT_ON], a_ctl[`TMRC_BIT_ON]};
    // RULE_02 idle stop
    t_stop[0] = idle_s && a_ctl[`TMRC_BIT_IDLE_STOP];
    t_stop[1] = idle_s && (e_ctl[`TMRC_BIT_IDLE_STOP] || (pair && o_ctl[`TMRC_BIT_IDLE_STOP]));
    t_stop[2] = idle_s && o_ctl[`TMRC_BIT_IDLE_STOP];
    t_cs = {o_ctl[`TMRC_BIT_CS], e_ctl[`TMRC_BIT_CS], a_ctl[`TMRC_BIT_CS]};
    // RULE_05 gate ignored with external source
    t_gate = {o_ctl[`TMRC_BIT_GATE], e_ctl[`TMRC_BIT_GATE], a_ctl[`TMRC_BIT_GATE]} & ~t_cs;
    t_shift[3:0] = a_shift(a_ctl[`TMRC_A_PS_HI:`TMRC_A_PS_LO]);
    t_shift[7:4] = b_shift(e_ctl[`TMRC_B_PS_HI:`TMRC_B_PS_LO]);
    t_shift[11:8] = b_shift(o_ctl[`TMRC_B_PS_HI:`TMRC_B_PS_LO]);
    if (pair) begin
      // RULE_10 odd controls ignored
      t_en[2] = t_en[1];
      t_stop[2] = t_stop[1];
      t_cs[2] = t_cs[1];
      t_gate[2] = t_gate[1];
      t_shift[11:8] = t_shift[7:4];
    end
    t_ld[0] = a_async ? a_done : a_wr_take;
    t_ld[1] = wr_go && (aw_addr == `TMRC_ADDR_E_CNT);
    t_ld[2] = wr_go && (aw_addr == `TMRC_ADDR_O_CNT);
    t_ld_val[15:0] = a_async ? a_wr_val : w_data[15:0];
    t_ld_val[31:16] = w_data[15:0];
    t_ld_val[47:32] = w_data[15:0];
  end

  // ==========================================================
  // Timer counters, one per timer
  wire [2:0] t_step;
  wire [2:0] t_wrap;
  wire [47:0] t_cnt;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : tmr
      reg [7:0] pre;
      reg [15:0] cnt;
      wire active = t_en[i] && !t_stop[i];
      // RULE_15 gate holds the count
      wire src = (t_cs[i] ? ext_rise[i] : 1'b1) && (!t_gate[i] || gate_s[i]);
      wire [7:0] pre_top = 8'hFF >> (4'h8 - t_shift[i*4 +: 4]);
      wire own = active && src && (pre == pre_top);
      // Odd half of a pair steps on the even half's wrap
      wire step;
      if (i == 2) begin : odd
        assign step = pair ? (t_step[1] && t_wrap[1]) : own;
      end else begin : base
        assign step = own;
      end
      assign t_step[i] = step;
      assign t_wrap[i] = (cnt == 16'hFFFF);
      assign t_cnt[i*16 +: 16] = cnt;

      // RULE_14 prescaled increment
      always @(posedge aclk) begin
        if (!aresetn) begin
          pre <= 8'h00;
          cnt <= `TMRC_CNT_RESET;
        end else begin
          if (!active) begin
            pre <= 8'h00;
          end else if (src) begin
            pre <= (pre == pre_top) ? 8'h00 : pre + 8'h01;
          end
          if (t_ld[i]) begin
            cnt <= t_ld_val[i*16 +: 16];
          end else if (step) begin
            cnt <= cnt + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // AXI4-Lite write channels, taken in either order
  wire aw_map = (awaddr == `TMRC_ADDR_A_CTL) || (awaddr == `TMRC_ADDR_A_CNT) ||
                (awaddr == `TMRC_ADDR_E_CTL) || (awaddr == `TMRC_ADDR_E_CNT) ||
                (awaddr == `TMRC_ADDR_O_CTL) || (awaddr == `TMRC_ADDR_O_CNT);
  reg aw_ok;

  // Ready pulses one cycle after valid so each item is taken once
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      aw_ok <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TMRC_RESP_OKAY;
    end else begin
      awready <= awvalid && !awready && !aw_held;
      wready <= wvalid && !wready && !w_held;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        aw_ok <= aw_map;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_ok ? `TMRC_RESP_OKAY : `TMRC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  reg [31:0] rd_mux;
  reg rd_ok;

  // Read view adds the live write-pending flag and hides type B gate bits while their source bit is 1
  always @* begin
    rd_ok = 1'b1;
    if (araddr == `TMRC_ADDR_A_CTL) begin
      rd_mux = a_ctl | ({31'h00000000, a_write_pending_flag} << `TMRC_BIT_WRITE_PENDING_FLAG);
    end else if (araddr == `TMRC_ADDR_A_CNT) begin
      rd_mux = {16'h0000, t_cnt[15:0]};
    end else if (araddr == `TMRC_ADDR_E_CTL) begin
      // RULE_06 gate reads zero
      rd_mux = e_ctl & ~({31'h00000000, e_ctl[`TMRC_BIT_CS]} << `TMRC_BIT_GATE);
    end else if (araddr == `TMRC_ADDR_E_CNT) begin
      rd_mux = {16'h0000, t_cnt[31:16]};
    end else if (araddr == `TMRC_ADDR_O_CTL) begin
      rd_mux = o_ctl & ~({31'h00000000, o_ctl[`TMRC_BIT_CS]} << `TMRC_BIT_GATE);
    end else if (araddr == `TMRC_ADDR_O_CNT) begin
      rd_mux = {16'h0000, t_cnt[47:32]};
    end else begin
      rd_ok = 1'b0;
      rd_mux = 32'h00000000;
    end
  end

  // Data is sampled at the address handshake and held until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TMRC_RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? `TMRC_RESP_OKAY : `TMRC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // tmrc_top

//--- testbench/test_tmrc_top.sv
`timescale 1ns/1ns
`include "tmrc_defines.vh"
// ==========================================
// Register-level bench for the timer control block
module test_tmrc_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdv;
  logic [31:0] cyc = 32'h0;
  logic [3:0] wstrb;
  logic [2:0] gate_in, ext_clk_in;
  logic [1:0] resp;
  logic [15:0] n;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int failures, checked, i;
  int sha [4] = '{0, 3, 6, 8};
  int shb [8] = '{0, 1, 2, 3, 4, 5, 6, 8};
  logic [31:0] mexp [3] = '{32'h0000B0B6, 32'h0000A07A, 32'h0000A072};
  // Longer async wait so the pending window is wide enough to probe
  tmrc_top #(.ASYNC_WR_CYCLES(40)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .idle_mode(idle_mode), .gate_in(gate_in), .ext_clk_in(ext_clk_in));
  // Clock
  always #5 aclk = ~aclk;
  // Cycle count and an external clock rising every 8 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 32'h1;
    ext_clk_in <= {3{cyc[2]}};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  // Offer address and data together; each is released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (wready === 1'b1) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end while (!(ta && tw));
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
  endtask
  // Steps over exactly 1024 cycles; the span is a multiple of every divisor
  task automatic span(input logic [7:0] a);
    logic [31:0] d0;
    repeat (8) @(posedge aclk);
    do @(posedge aclk); while (cyc[9:0] != 10'h000);
    rd(a);
    d0 = rdv;
    do @(posedge aclk); while (cyc[9:0] != 10'h000);
    rd(a);
    n = rdv[15:0] - d0[15:0];
  endtask
  // Watchdog sized well above the expected run of about 40000 cycles
  initial begin
    repeat (80000) @(posedge aclk);
    failures++;
    close_out;
  end
  // Main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, idle_mode} = 6'h00;
    {bready, rready, wstrb} = 6'h3F;
    {awaddr, araddr, wdata, gate_in} = 51'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      check(rdv, 32'h0);
    end
    for (i = 0; i < 3; i++) begin
      wr(8'(8 * i), 32'hFFFFFFFF);
      rd(8'(8 * i));
      check(rdv, mexp[i]);
      wr(8'(8 * i), 32'h0);
    end
    wr(8'h18, 32'hFFFFFFFF);
    check(resp, `TMRC_RESP_SLVERR);
    rd(8'h18);
    check(rdv, 32'h0);
    note("register map");
    for (i = 0; i < 4; i++) begin
      wr(8'h00, 32'h8000 | (i << 4));
      span(8'h04);
      check(n, 1024 >> sha[i]);
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h08, 32'h8000 | (i << 4));
      span(8'h0C);
      check(n, 1024 >> shb[i]);
    end
    wr(8'h08, 32'h0);
    span(8'h0C);
    check(n, 0);
    note("prescale");
    wr(8'h00, 32'h8080);
    span(8'h04);
    check(n, 0);
    gate_in <= 3'h7;
    span(8'h04);
    check(n, 1024);
    gate_in <= 3'h0;
    wr(8'h00, 32'h8086);
    span(8'h04);
    check(n, 128);
    idle_mode <= 1'b1;
    wr(8'h08, 32'hA000);
    span(8'h0C);
    check(n, 0);
    wr(8'h08, 32'h8000);
    span(8'h0C);
    check(n, 1024);
    note("gate and idle");
    // Still idle: odd half disabled and slow, both ignored when paired, and its idle-stop clear
    wr(8'h10, 32'h0070);
    wr(8'h14, 32'h0);
    wr(8'h0C, 32'hFF00);
    wr(8'h08, 32'h8008);
    repeat (1000) @(posedge aclk);
    rd(8'h14);
    check(rdv, 32'h1);
    // Odd idle-stop set halts the whole pair while idle
    wr(8'h10, 32'h2000);
    span(8'h0C);
    check(n, 0);
    idle_mode <= 1'b0;
    wr(8'h08, 32'h0); // next access is two cycles later at the soonest
    note("pair");
    wr(8'h00, 32'h1002);
    wr(8'h04, 32'h1234);
    rd(8'h00);
    check(rdv, 32'h1802);
    wr(8'h04, 32'h5555);
    repeat (50) @(posedge aclk);
    rd(8'h00);
    check(rdv, 32'h1002);
    rd(8'h04);
    check(rdv, 32'h1234);
    wr(8'h00, 32'h0002);
    wr(8'h04, 32'h1111);
    wr(8'h04, 32'h2222);
    repeat (50) @(posedge aclk);
    rd(8'h04);
    check(rdv, 32'h2222);
    wr(8'h00, 32'h0006);
    wr(8'h04, 32'h0077);
    rd(8'h00);
    check(rdv, 32'h0006);
    rd(8'h04);
    check(rdv, 32'h0077);
    note("async write");
    close_out;
  end
endmodule // test_tmrc_top
bind tmrc_top tmrc_assertions i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
  .rdata(rdata), .rresp(rresp));

//--- testbench/tmrc_assertions.sv
`timescale 1ns/1ns
`include "tmrc_defines.vh"
// ==========================================
// Bus and read-back checker on the top ports
module tmrc_assertions (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Write channels
  input logic awvalid,
  input logic awready,
  input logic [7:0] awaddr,
  input logic wvalid,
  input logic wready,
  input logic bvalid,
  input logic [1:0] bresp,
  // Read channels
  input logic arvalid,
  input logic arready,
  input logic [7:0] araddr,
  input logic rvalid,
  input logic [31:0] rdata,
  input logic [1:0] rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Anything past the last count word or off a word boundary is unmapped
  function automatic logic bad(input logic [7:0] a);
    return (a > 8'h14) || (a[1:0] != 2'h0);
  endfunction
  // Both write channels taken at one edge
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // Read address taken
  sequence rd_take;
    arvalid && arready;
  endsequence
  chk_upper_zero: assert property (
    rvalid |-> rdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_rd_unmapped: assert property (
    rd_take ##0 bad(araddr) |=> rvalid && rresp == `TMRC_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_wr_unmapped: assert property (
    wr_take ##0 bad(awaddr) |=> ##1 bvalid && bresp == `TMRC_RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_wr_okay: assert property (
    wr_take ##0 !bad(awaddr) |=> ##1 bvalid && bresp == `TMRC_RESP_OKAY)
    else $error("mapped write refused");
  chk_flag_sync: assert property (
    rd_take ##0 araddr == 8'h00 ##1 (rvalid && rdata[2]) |-> !rdata[11])
    else $error("pending flag set in sync mode");
  chk_gate_hidden: assert property (
    rd_take ##0 (araddr == 8'h08 || araddr == 8'h10) ##1 (rvalid && rdata[1]) |-> !rdata[7])
    else $error("gate bit visible with external source");
  chk_odd_no_pair: assert property (
    rd_take ##0 araddr == 8'h10 |=> rvalid && !rdata[3]) else $error("odd pair bit set");
  chk_a_unused: assert property (
    rd_take ##0 araddr == 8'h00 |=> rvalid && (rdata & ~32'h0000B8B6) == 32'h0)
    else $error("unused bit set in timer A control");
  chk_b_unused: assert property (
    rd_take ##0 araddr == 8'h08 |=> rvalid && (rdata & ~32'h0000A0FA) == 32'h0)
    else $error("unused bit set in even control");
endmodule // tmrc_assertions
